// [hw/ivm_pkg.sv]
`default_nettype none
package ivm_pkg;
  // table shape
  localparam int          IVM_NUM_USER   = 32;
  localparam logic [31:0] IVM_VEC_STACK  = 32'h0000_0000;
  localparam logic [31:0] IVM_CORE_FIRST = 32'h0000_0000;
  localparam logic [31:0] IVM_CORE_LAST  = 32'h0000_003c;
  localparam logic [31:0] IVM_USER_BASE  = 32'h0000_0040;
  localparam logic [31:0] IVM_USER_LAST  = 32'h0000_00bc;

  // exception numbers, vector address is four times the number
  localparam logic [5:0]  IVM_EXC_STACK      = 6'h00;
  localparam logic [5:0]  IVM_EXC_RESET      = 6'h01;
  localparam logic [5:0]  IVM_EXC_NMI        = 6'h02;
  localparam logic [5:0]  IVM_EXC_HARD_FAULT = 6'h03;
  localparam logic [5:0]  IVM_EXC_SVC        = 6'h0b;
  localparam logic [5:0]  IVM_EXC_PENDABLE_SERVICE_EXCEPTION     = 6'h0e;
  localparam logic [5:0]  IVM_EXC_SYSTICK    = 6'h0f;
  localparam logic [5:0]  IVM_EXC_USER_FIRST = 6'h10;
  localparam logic [5:0]  IVM_EXC_USER_LAST  = 6'h2f;

  // priorities, two's complement
  localparam logic [7:0]  IVM_PRIO_RESET      = 8'hfd;
  localparam logic [7:0]  IVM_PRIO_NMI        = 8'hfe;
  localparam logic [7:0]  IVM_PRIO_HARD_FAULT = 8'hff;
  localparam logic [7:0]  IVM_PRIO_SVC_INIT   = 8'h03;
  localparam logic [7:0]  IVM_PRIO_PENDABLE_SERVICE_EXCEPTION_INIT = 8'h05;
  localparam logic [7:0]  IVM_PRIO_SYSTICK_INIT = 8'h06;
  localparam logic [7:0]  IVM_PRIO_USER_INIT  = 8'h00;

  // user line of each source
  localparam logic [4:0]  IVM_LINE_GPIO      = 5'h00;
  localparam logic [4:0]  IVM_LINE_FLASH     = 5'h01;
  localparam logic [4:0]  IVM_LINE_UART      = 5'h04;
  localparam logic [4:0]  IVM_LINE_SPI       = 5'h05;
  localparam logic [4:0]  IVM_LINE_RADIO     = 5'h06;
  localparam logic [4:0]  IVM_LINE_WATCHDOG  = 5'h07;
  localparam logic [4:0]  IVM_LINE_ADC       = 5'h0d;
  localparam logic [4:0]  IVM_LINE_I2C_TWO   = 5'h0e;
  localparam logic [4:0]  IVM_LINE_I2C_ONE   = 5'h0f;
  localparam logic [4:0]  IVM_LINE_MFT_ONE_A = 5'h11;
  localparam logic [4:0]  IVM_LINE_MFT_ONE_B = 5'h12;
  localparam logic [4:0]  IVM_LINE_MFT_TWO_A = 5'h13;
  localparam logic [4:0]  IVM_LINE_MFT_TWO_B = 5'h14;
  localparam logic [4:0]  IVM_LINE_RTC       = 5'h15;
  localparam logic [4:0]  IVM_LINE_PKA       = 5'h16;
  localparam logic [4:0]  IVM_LINE_DMA       = 5'h17;

  // lines with a source attached; all others are reserved
  localparam logic [31:0] IVM_WIRED_LINES = 32'h00fe_e0f3;

  typedef enum logic [2:0]
  {
    IVM_PT_NONE,
    IVM_PT_FIXED,
    IVM_PT_SETTABLE,
    IVM_PT_CRITICAL,
    IVM_PT_RESERVED
  } ivm_ptype_t;
endpackage
`default_nettype wire

// [hw/ivm_top.sv]
// Operation
// - thirty-two user lines, vectors 0x40 to 0xbc
// - core vectors 0x00 to 0x3c, below user
// - first table word holds initial stack pointer
// - reset at word one, fixed priority -3
// - non-maskable at word two, fixed priority -2
// - hard fault at 0x0c, fixed priority -1
// - supervisor call at 0x2c, settable, starts 3
// - pendable service at 0x38, settable, starts 5
// - system tick at 0x3c, settable, starts 6
// - gpio line 0, flash line 1
// - uart line 4, spi line 5
// - radio link line 6, critical class
// - watchdog drives line 7
// - adc drives line 13
// - second i2c line 14, first line 15
// - timers a/b onto lines 17 to 20
// - rtc line 21, key accelerator line 22
// - dma drives line 23
// - remaining lines reserved, no source
// - user priorities start 0, software writable except critical line 6
// - user lines come from on-chip peripherals
`default_nettype none
module ivm_top
  import ivm_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // peripheral requests, same clock domain
  input  wire logic                gpio_irq,
  input  wire logic                flash_irq,
  input  wire logic                uart_irq,
  input  wire logic                spi_irq,
  input  wire logic                radio_link_controller_irq,
  input  wire logic                watchdog_irq,
  input  wire logic                adc_irq,
  input  wire logic                i2c_two_irq,
  input  wire logic                i2c_one_irq,
  input  wire logic                multifunction_timer_one_a_irq,
  input  wire logic                multifunction_timer_one_b_irq,
  input  wire logic                multifunction_timer_two_a_irq,
  input  wire logic                multifunction_timer_two_b_irq,
  input  wire logic                rtc_irq,
  input  wire logic                public_key_accelerator_irq,
  input  wire logic                dma_irq,
  // requests to the nested_vectored_irq_unit
  output logic [31:0]              user_irq,
  // priority write from the core
  input  wire logic                prio_wr_en,
  input  wire logic [5:0]          prio_wr_exc,
  input  wire logic [7:0]          prio_wr_val,
  output logic                     prio_wr_ack,
  output logic                     prio_wr_refused,
  // vector table lookup
  input  wire logic                query_valid,
  input  wire logic [5:0]          query_exc,
  output logic                     rsp_valid,
  output logic [31:0]              rsp_addr,
  output logic [7:0]               rsp_prio,
  output ivm_pkg::ivm_ptype_t      rsp_type,
  output logic                     rsp_handler,
  output logic                     rsp_wired,
  output logic                     rsp_in_table
);
  import ivm_pkg::*;

  // write target, decoded once so the refusal list lives in one place
  typedef enum logic [2:0]
  {
    IVM_WR_USER,
    IVM_WR_SVC,
    IVM_WR_PENDABLE_SERVICE_EXCEPTION,
    IVM_WR_SYSTICK,
    IVM_WR_REFUSE
  } ivm_wr_t;

  typedef struct packed {
    logic [31:0]       irq;
    logic [31:0][7:0]  user_prio;
    logic [7:0]        svc_prio;
    logic [7:0]        pendable_service_exception_prio;
    logic [7:0]        systick_prio;
    logic              wr_ack;
    logic              wr_refused;
    logic              rsp_valid;
    logic [31:0]       rsp_addr;
    logic [7:0]        rsp_prio;
    ivm_ptype_t        rsp_type;
    logic              rsp_handler;
    logic              rsp_wired;
    logic              rsp_in_table;
  } ivm_state_t;

  ivm_state_t  s_q;
  ivm_state_t  s_d;
  logic [31:0] raw_irq;
  logic [5:0]  wr_off;
  logic [4:0]  wr_line;
  logic        wr_user;
  logic [5:0]  q_off;
  logic [4:0]  q_line;
  logic        q_user;
  logic        q_wired;
  ivm_ptype_t  q_type;
  ivm_wr_t     wr_target;

  always_comb
  begin
    s_d            = s_q;
    s_d.wr_ack     = 1'b0;
    s_d.wr_refused = 1'b0;
    s_d.rsp_valid  = 1'b0;

    // each line fed from its on-chip source, never a pin
    raw_irq                     = '0;
    raw_irq[IVM_LINE_GPIO]      = gpio_irq;
    raw_irq[IVM_LINE_FLASH]     = flash_irq;
    raw_irq[IVM_LINE_UART]      = uart_irq;
    raw_irq[IVM_LINE_SPI]       = spi_irq;
    raw_irq[IVM_LINE_RADIO]     = radio_link_controller_irq;
    raw_irq[IVM_LINE_WATCHDOG]  = watchdog_irq;
    raw_irq[IVM_LINE_ADC]       = adc_irq;
    raw_irq[IVM_LINE_I2C_TWO]   = i2c_two_irq;
    raw_irq[IVM_LINE_I2C_ONE]   = i2c_one_irq;
    raw_irq[IVM_LINE_MFT_ONE_A] = multifunction_timer_one_a_irq;
    raw_irq[IVM_LINE_MFT_ONE_B] = multifunction_timer_one_b_irq;
    raw_irq[IVM_LINE_MFT_TWO_A] = multifunction_timer_two_a_irq;
    raw_irq[IVM_LINE_MFT_TWO_B] = multifunction_timer_two_b_irq;
    raw_irq[IVM_LINE_RTC]       = rtc_irq;
    raw_irq[IVM_LINE_PKA]       = public_key_accelerator_irq;
    raw_irq[IVM_LINE_DMA]       = dma_irq;
    // mask is a constant so a stray edit above cannot wake a reserved line
    s_d.irq = raw_irq & IVM_WIRED_LINES;

    // priority writes; fixed and critical entries refuse
    wr_off  = prio_wr_exc - IVM_EXC_USER_FIRST;
    wr_line = wr_off[4:0];
    wr_user = (prio_wr_exc >= IVM_EXC_USER_FIRST) && (prio_wr_exc <= IVM_EXC_USER_LAST);

    case (prio_wr_exc)
      IVM_EXC_SVC:
      begin
        wr_target = IVM_WR_SVC;
      end

      IVM_EXC_PENDABLE_SERVICE_EXCEPTION:
      begin
        wr_target = IVM_WR_PENDABLE_SERVICE_EXCEPTION;
      end

      IVM_EXC_SYSTICK:
      begin
        wr_target = IVM_WR_SYSTICK;
      end

      default:
      begin
        if (wr_user && (wr_line != IVM_LINE_RADIO))
        begin
          wr_target = IVM_WR_USER;
        end
        else
        begin
          // reset, nmi, hard fault, critical line and holes stay put
          wr_target = IVM_WR_REFUSE;
        end
      end
    endcase

    if (prio_wr_en)
    begin
      case (wr_target)
        IVM_WR_USER:
        begin
          s_d.user_prio[wr_line] = prio_wr_val;
          s_d.wr_ack             = 1'b1;
        end

        IVM_WR_SVC:
        begin
          s_d.svc_prio = prio_wr_val;
          s_d.wr_ack   = 1'b1;
        end

        IVM_WR_PENDABLE_SERVICE_EXCEPTION:
        begin
          s_d.pendable_service_exception_prio = prio_wr_val;
          s_d.wr_ack      = 1'b1;
        end

        IVM_WR_SYSTICK:
        begin
          s_d.systick_prio = prio_wr_val;
          s_d.wr_ack       = 1'b1;
        end

        default:
        begin
          s_d.wr_refused = 1'b1;
        end
      endcase
    end

    // table lookup, answered one cycle after the query
    q_off  = query_exc - IVM_EXC_USER_FIRST;
    q_line = q_off[4:0];
    q_user = (query_exc >= IVM_EXC_USER_FIRST) && (query_exc <= IVM_EXC_USER_LAST);

    // per-line class and source presence
    q_type = IVM_PT_SETTABLE;
    case (q_line)
      IVM_LINE_RADIO:
      begin
        q_type = IVM_PT_CRITICAL;
      end
      default:
      begin
        q_type = IVM_PT_SETTABLE;
      end
    endcase
    q_wired = IVM_WIRED_LINES[q_line];

    if (query_valid)
    begin
      s_d.rsp_valid    = 1'b1;
      s_d.rsp_addr     = {24'h00_0000, query_exc, 2'b00};
      s_d.rsp_prio     = 8'h00;
      s_d.rsp_type     = IVM_PT_RESERVED;
      s_d.rsp_handler  = 1'b0;
      s_d.rsp_wired    = 1'b0;
      s_d.rsp_in_table = 1'b1;
      case (query_exc)
        IVM_EXC_STACK:
        begin
          // word zero is data, not a handler
          s_d.rsp_addr = IVM_VEC_STACK;
          s_d.rsp_type = IVM_PT_NONE;
        end

        IVM_EXC_RESET:
        begin
          s_d.rsp_prio    = IVM_PRIO_RESET;
          s_d.rsp_type    = IVM_PT_FIXED;
          s_d.rsp_handler = 1'b1;
        end

        IVM_EXC_NMI:
        begin
          s_d.rsp_prio    = IVM_PRIO_NMI;
          s_d.rsp_type    = IVM_PT_FIXED;
          s_d.rsp_handler = 1'b1;
        end

        IVM_EXC_HARD_FAULT:
        begin
          s_d.rsp_prio    = IVM_PRIO_HARD_FAULT;
          s_d.rsp_type    = IVM_PT_FIXED;
          s_d.rsp_handler = 1'b1;
        end

        IVM_EXC_SVC:
        begin
          s_d.rsp_prio    = s_q.svc_prio;
          s_d.rsp_type    = IVM_PT_SETTABLE;
          s_d.rsp_handler = 1'b1;
        end

        IVM_EXC_PENDABLE_SERVICE_EXCEPTION:
        begin
          s_d.rsp_prio    = s_q.pendable_service_exception_prio;
          s_d.rsp_type    = IVM_PT_SETTABLE;
          s_d.rsp_handler = 1'b1;
        end

        IVM_EXC_SYSTICK:
        begin
          s_d.rsp_prio    = s_q.systick_prio;
          s_d.rsp_type    = IVM_PT_SETTABLE;
          s_d.rsp_handler = 1'b1;
        end

        default:
        begin
          if (q_user)
          begin
            s_d.rsp_addr    = IVM_USER_BASE + {25'h000_0000, q_line, 2'b00};
            s_d.rsp_prio    = s_q.user_prio[q_line];
            s_d.rsp_type    = q_type;
            s_d.rsp_handler = 1'b1;
            s_d.rsp_wired   = q_wired;
          end
          else if (query_exc > IVM_EXC_USER_LAST)
          begin
            // beyond the last user vector: nothing there
            s_d.rsp_addr     = 32'h0000_0000;
            s_d.rsp_type     = IVM_PT_NONE;
            s_d.rsp_in_table = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_q              <= '0;
      s_q.irq          <= '0;
      s_q.wr_ack       <= 1'b0;
      s_q.wr_refused   <= 1'b0;
      s_q.rsp_valid    <= 1'b0;
      s_q.rsp_addr     <= 32'h0000_0000;
      s_q.rsp_prio     <= 8'h00;
      s_q.rsp_handler  <= 1'b0;
      s_q.rsp_wired    <= 1'b0;
      s_q.rsp_in_table <= 1'b0;
      s_q.user_prio    <= {IVM_NUM_USER{IVM_PRIO_USER_INIT}};
      s_q.svc_prio     <= IVM_PRIO_SVC_INIT;
      s_q.pendable_service_exception_prio  <= IVM_PRIO_PENDABLE_SERVICE_EXCEPTION_INIT;
      s_q.systick_prio <= IVM_PRIO_SYSTICK_INIT;
      s_q.rsp_type     <= IVM_PT_NONE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // every output straight from the state register; requests lag sources by one cycle
  assign user_irq        = s_q.irq;
  assign prio_wr_ack     = s_q.wr_ack;
  assign prio_wr_refused = s_q.wr_refused;
  assign rsp_valid       = s_q.rsp_valid;
  assign rsp_addr        = s_q.rsp_addr;
  assign rsp_prio        = s_q.rsp_prio;
  assign rsp_type        = s_q.rsp_type;
  assign rsp_handler     = s_q.rsp_handler;
  assign rsp_wired       = s_q.rsp_wired;
  assign rsp_in_table    = s_q.rsp_in_table;
endmodule
`default_nettype wire

// [verification/ivm_core_model.sv]
`default_nettype none
module ivm_core_model
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // request lines from the block
  input  wire logic [31:0] user_irq,
  // lines seen high since reset
  output logic      [31:0] seen_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // level requests: logging sampled highs is all the core can tell apart
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      seen_q <= 32'h0;
    else
      seen_q <= seen_q | user_irq;
  end
endmodule
`default_nettype wire

// [verification/ivm_assertions.sv]
`default_nettype none
module ivm_assertions
  import ivm_pkg::*;
(
  // clock and reset
  input wire logic                clk,
  input wire logic                rst_b,
  // watched ports
  input wire logic                uart_irq,
  input wire logic [31:0]         user_irq,
  input wire logic                prio_wr_en,
  input wire logic [5:0]          prio_wr_exc,
  input wire logic                prio_wr_ack,
  input wire logic                prio_wr_refused,
  input wire logic                query_valid,
  input wire logic [5:0]          query_exc,
  input wire logic [31:0]         rsp_addr,
  input wire logic [7:0]          rsp_prio,
  input wire ivm_pkg::ivm_ptype_t rsp_type,
  input wire logic                rsp_handler,
  input wire logic                rsp_in_table
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  reserved_idle_a: assert property ((user_irq & ~32'h00fe_e0f3) == 32'h0)
    else $error("reserved line raised");
  uart_follow_a: assert property ($past(rst_b) |-> user_irq[4] == $past(uart_irq))
    else $error("uart line wrong");
  write_answer_a: assert property (prio_wr_en |=> prio_wr_ack != prio_wr_refused)
    else $error("write not answered once");
  critical_refused_a: assert property (prio_wr_en && prio_wr_exc == 6'h16 |=> prio_wr_refused)
    else $error("critical line write taken");
  fixed_refused_a: assert property (prio_wr_en && prio_wr_exc inside {6'h01, 6'h02, 6'h03}
    |=> prio_wr_refused)
    else $error("fixed priority write taken");
  user_addr_a: assert property (query_valid && query_exc inside {[6'h10:6'h2f]}
    |=> rsp_addr == {24'h0, $past(query_exc), 2'b00})
    else $error("user vector address wrong");
  reset_prio_a: assert property (query_valid && query_exc == 6'h01
    |=> rsp_prio == 8'hfd && rsp_type == IVM_PT_FIXED && rsp_addr == 32'h4)
    else $error("reset entry wrong");
  stack_word_a: assert property (query_valid && query_exc == 6'h00
    |=> rsp_addr == 32'h0 && !rsp_handler)
    else $error("stack word entry wrong");
  in_table_a: assert property (query_valid |=> rsp_in_table == ($past(query_exc) <= 6'd47))
    else $error("table range wrong");
endmodule
bind ivm_top ivm_assertions chk (.*);
`default_nettype wire

// [verification/interrupt_vector_map_tb.sv]
`default_nettype none
module interrupt_vector_map_tb;
  import ivm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0]  LN [16] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0d, 5'h0e,
                                     5'h0f, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17};
  localparam logic [31:0] WIRED   = 32'h00fe_e0f3;
  logic        clk, rst_b, prio_wr_en, query_valid, prio_wr_ack, prio_wr_refused;
  logic        rsp_valid, rsp_handler, rsp_wired, rsp_in_table;
  logic        gpio_irq, flash_irq, uart_irq, spi_irq, radio_link_controller_irq, watchdog_irq;
  logic        adc_irq, i2c_two_irq, i2c_one_irq, rtc_irq, public_key_accelerator_irq, dma_irq;
  logic        multifunction_timer_one_a_irq, multifunction_timer_one_b_irq;
  logic        multifunction_timer_two_a_irq, multifunction_timer_two_b_irq;
  logic [5:0]  prio_wr_exc, query_exc;
  logic [7:0]  prio_wr_val, rsp_prio;
  logic [15:0] src;
  logic [31:0] user_irq, rsp_addr, seen;
  ivm_ptype_t  rsp_type;
  int          errors, comparisons, cycles;

  assign {dma_irq, public_key_accelerator_irq, rtc_irq, multifunction_timer_two_b_irq,
          multifunction_timer_two_a_irq, multifunction_timer_one_b_irq,
          multifunction_timer_one_a_irq, i2c_one_irq, i2c_two_irq, adc_irq, watchdog_irq,
          radio_link_controller_irq, spi_irq, uart_irq, flash_irq, gpio_irq} = src;
  ivm_top dut (.*);
  ivm_core_model core (.clk(clk), .rst_b(rst_b), .user_irq(user_irq), .seen_q(seen));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // a hang is cut short well past the under two hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // m selects which of prio, type, handler are judged
  task automatic query(input logic [5:0] e, input logic [31:0] a, input logic [7:0] p,
                       input ivm_ptype_t t, input logic h, input logic [2:0] m);
    @(negedge clk);
    query_valid = 1'b1;
    query_exc = e;
    @(negedge clk);
    query_valid = 1'b0;
    check(rsp_valid, 32'h1, "rsp_valid");
    check(rsp_addr, a, "addr");
    check(rsp_in_table, e <= 6'd47, "in_table");
    if (m[0])
      check(rsp_prio, p, "prio");
    if (m[1])
      check(rsp_type, t, "type");
    if (m[2])
      check(rsp_handler, h, "handler");
  endtask

  task automatic write(input logic [5:0] e, input logic [7:0] v, input logic ok);
    @(negedge clk);
    prio_wr_en = 1'b1;
    prio_wr_exc = e;
    prio_wr_val = v;
    @(negedge clk);
    prio_wr_en = 1'b0;
    check({prio_wr_ack, prio_wr_refused}, {ok, !ok}, "write answer");
  endtask

  task automatic t_core();
    check(user_irq, 32'h0, "idle lines");
    query(6'h05, 32'h14, 8'h00, IVM_PT_RESERVED, 1'b0, 3'b111);
    query(6'h0b, 32'h2c, 8'h03, IVM_PT_SETTABLE, 1'b1, 3'b111);
    query(6'h0e, 32'h38, 8'h05, IVM_PT_SETTABLE, 1'b1, 3'b111);
    query(6'h0f, 32'h3c, 8'h06, IVM_PT_SETTABLE, 1'b1, 3'b111);
    query(6'h01, 32'h04, 8'hfd, IVM_PT_FIXED, 1'b1, 3'b111);
    query(6'h02, 32'h08, 8'hfe, IVM_PT_FIXED, 1'b1, 3'b111);
    query(6'h03, 32'h0c, 8'hff, IVM_PT_FIXED, 1'b1, 3'b111);
    query(6'h00, 32'h00, 8'h00, IVM_PT_NONE, 1'b0, 3'b100);
    query(6'h30, 32'h00, 8'h00, IVM_PT_NONE, 1'b0, 3'b000);
    $display("test core done");
  endtask

  task automatic t_user();
    for (int n = 0; n < 32; n++)
    begin
      query(6'(16 + n), 32'h40 + 32'(4 * n), 8'h00, n == 6 ? IVM_PT_CRITICAL : IVM_PT_SETTABLE,
            1'b1, WIRED[n] ? 3'b111 : 3'b011);
      check(rsp_wired, 32'(WIRED[n]), "wired");
    end
    $display("test user done");
  endtask

  task automatic t_map();
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clk);
      src = 16'h1 << i;
      @(negedge clk);
      check(user_irq, 32'h1 << LN[i], "line map");
    end
    @(negedge clk);
    src = 16'hffff;
    @(negedge clk);
    check(user_irq, WIRED, "all sources");
    check(seen, WIRED, "core saw");
    src = 16'h0;
    @(negedge clk);
    check(user_irq, 32'h0, "released");
    $display("test map done");
  endtask

  task automatic t_write();
    write(6'h10, 8'h02, 1'b1);
    query(6'h10, 32'h40, 8'h02, IVM_PT_SETTABLE, 1'b1, 3'b111);
    write(6'h16, 8'h01, 1'b0);
    query(6'h16, 32'h58, 8'h00, IVM_PT_CRITICAL, 1'b1, 3'b111);
    write(6'h01, 8'h00, 1'b0);
    query(6'h01, 32'h04, 8'hfd, IVM_PT_FIXED, 1'b1, 3'b111);
    write(6'h0b, 8'h07, 1'b1);
    query(6'h0b, 32'h2c, 8'h07, IVM_PT_SETTABLE, 1'b1, 3'b111);
    write(6'h30, 8'h01, 1'b0);
    write(6'h0e, 8'h09, 1'b1);
    query(6'h0e, 32'h38, 8'h09, IVM_PT_SETTABLE, 1'b1, 3'b111);
    write(6'h0f, 8'h0a, 1'b1);
    query(6'h0f, 32'h3c, 8'h0a, IVM_PT_SETTABLE, 1'b1, 3'b111);
    write(6'h02, 8'h00, 1'b0);
    write(6'h03, 8'h00, 1'b0);
    write(6'h05, 8'h01, 1'b0);
    write(6'h12, 8'h04, 1'b1);
    $display("test write done");
  endtask

  // second reset in mid-run: outputs clear, priorities return to start values
  task automatic t_reset();
    @(negedge clk);
    rst_b = 1'b0;
    src = 16'hffff;
    repeat (2) @(negedge clk);
    check(user_irq, 32'h0, "reset lines");
    check(rsp_valid, 32'h0, "reset rsp_valid");
    check(rsp_addr, 32'h0, "reset addr");
    check(rsp_wired, 32'h0, "reset wired");
    check(prio_wr_ack, 32'h0, "reset ack");
    src = 16'h0;
    rst_b = 1'b1;
    query(6'h10, 32'h40, 8'h00, IVM_PT_SETTABLE, 1'b1, 3'b111);
    query(6'h0b, 32'h2c, 8'h03, IVM_PT_SETTABLE, 1'b1, 3'b111);
    query(6'h0e, 32'h38, 8'h05, IVM_PT_SETTABLE, 1'b1, 3'b111);
    query(6'h0f, 32'h3c, 8'h06, IVM_PT_SETTABLE, 1'b1, 3'b111);
    $display("test reset done");
  endtask

  initial
  begin
    rst_b = 1'b0;
    src = 16'h0;
    prio_wr_en = 1'b0;
    prio_wr_exc = 6'h00;
    prio_wr_val = 8'h00;
    query_valid = 1'b0;
    query_exc = 6'h00;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    t_core();
    t_user();
    t_map();
    t_write();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
